// [verilog/lqm_pkg.sv]
// Notes on behaviour
// - Threshold checking runs only while the monitor enable bit 15 is set and a valid 100 Mb link is present.
// - A threshold programmed to its maximum (high) or minimum (low) value can never be violated, so it is off.
// - A threshold violation while interrupt generation is armed raises the interrupt output when the link quality interrupt is unmasked.
// - A read of the monitor control register clears its warning flags, except any violated in the read cycle, and re-arms interrupt generation.
// - With bit 14 set, a frequency control violation resets the DSP and restarts 100 Mb adaptation.
// - With bit 13 set, a frequency offset violation resets the DSP and restarts 100 Mb adaptation.
// - With bit 12 set, a baseline wander violation resets the DSP and restarts 100 Mb adaptation.
// - With bit 11 set, a digital gain violation resets the DSP and restarts 100 Mb adaptation.
// - With bit 10 set, an equalizer coefficient violation resets the DSP and restarts 100 Mb adaptation.
// - An enabled restart also drops link status when the signal detect option bit 8 of the PCS control is 0.
// - Frequency control high sets flag bit 9 and low sets flag bit 8; both clear on read.
// - Frequency offset high sets flag bit 7 and low sets flag bit 6; both clear on read.
// - Baseline wander high sets flag bit 5 and low sets flag bit 4; both clear on read.
// - Digital gain high sets flag bit 3 and low sets flag bit 2; both clear on read.
// - Equalizer coefficient high sets flag bit 1 and low sets flag bit 0; both clear on read.
package lqm_pkg;
	// parameter slots, also the order of flag pairs and restart bits
	localparam int NUM_PARAMS = 5;
	localparam int PARAM_EQ   = 0;
	localparam int PARAM_DG   = 1;
	localparam int PARAM_BLW  = 2;
	localparam int PARAM_FO   = 3;
	localparam int PARAM_FC   = 4;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL       = 8'h1D;
	localparam logic [7:0] IDX_PCS_CTRL   = 8'h10;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h12;
	localparam logic [7:0] IDX_IRQ_MASK   = 8'h13;
	localparam logic [7:0] IDX_THR_BASE   = 8'h20;

	// field positions
	localparam int BIT_MON_ON      = 15;
	localparam int BIT_RESTART_LO  = 10;
	localparam int BIT_SIGNAL_DETECT_OPTION   = 8;
	localparam int BIT_IRQ_LQ      = 0;
	localparam int BIT_THR_HI_LO   = 8;
	localparam int FLAG_W          = 2 * NUM_PARAMS;
	localparam int CFG_W           = NUM_PARAMS + 1;

	// reset values
	localparam logic [CFG_W-1:0]  RST_CFG     = 6'h00;
	localparam logic [FLAG_W-1:0] RST_FLAGS   = 10'h000;
	localparam logic [7:0]        RST_THR_LO  = 8'h00;
	localparam logic [7:0]        RST_THR_HI  = 8'hFF;
	localparam logic              RST_SD_OPT  = 1'b0;
	localparam logic              RST_MASK    = 1'b0;

	// adapted DSP parameters as delivered by the receiver
	typedef struct packed {
		logic [7:0] fc;
		logic [7:0] fo;
		logic [7:0] blw;
		logic [7:0] dg;
		logic [7:0] eq;
	} dsp_params_t;

	// one threshold register, high byte over low byte
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} thr_pair_t;

	// captured address phase
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] idx;
	} ahb_req_t;
endpackage : lqm_pkg

// [verilog/level_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for levels arriving from outside this clock
module level_sync #(
	parameter int W = 1
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);
	logic [W-1:0] meta_ff;

	// first stage feeds only the second
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_ff  <= '0;
			sync_out <= '0;
		end else begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule : level_sync
`default_nettype wire

// [verilog/threshold_check.sv]
`timescale 1ns/1ps
`default_nettype none
// unsigned window compare of one parameter against its limits
module threshold_check #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] value,
	input  wire logic [W-1:0] thr_lo,
	input  wire logic [W-1:0] thr_hi,
	input  wire logic         active,
	output var  logic         over_hi,
	output var  logic         under_lo
);
	// strict compares: all-ones high or zero low can never trip
	always_comb begin
		over_hi  = active && (value > thr_hi);
		under_lo = active && (value < thr_lo);
	end
endmodule : threshold_check
`default_nettype wire

// [verilog/link_quality_monitor_ctrl.sv]
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module link_quality_monitor_ctrl
	import lqm_pkg::*;
#(
	parameter int VAL_W = 8
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	input  wire logic        link_100_valid,
	input  wire dsp_params_t dsp_params,
	output var  logic        irq,
	output var  logic        dsp_restart,
	output var  logic        link_drop
);
	// register state
	logic [CFG_W-1:0]  cfg_ff;
	logic [FLAG_W-1:0] flags_ff;
	logic [FLAG_W-1:0] nxt_flags;
	logic              sd_opt_ff;
	logic              irq_status_ff;
	logic              nxt_irq_status;
	logic              irq_mask_ff;
	logic              armed_ff;
	logic              nxt_armed;
	thr_pair_t         thr_ff [NUM_PARAMS];
	ahb_req_t          req_ff;
	logic [FLAG_W-1:0] prev_viol_ff;

	// combinational helpers
	logic              link_ok;
	logic              mon_active;
	logic [FLAG_W-1:0] viol;
	logic              any_viol;
	logic [VAL_W-1:0]  values [NUM_PARAMS];
	logic [NUM_PARAMS-1:0] new_viol;
	logic [NUM_PARAMS-1:0] restart_hit;
	logic              addr_ok;
	logic              take;
	logic [7:0]        a_idx;
	logic              rd_ctrl;
	logic              rd_irq_status;
	logic [31:0]       nxt_rdata;
	logic [2:0]        thr_sel;

	// link status arrives from the PCS side, treat it as foreign
	level_sync #(
		.W(1)
	) u_link_sync (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in (link_100_valid),
		.sync_out (link_ok)
	);

	assign mon_active = cfg_ff[BIT_MON_ON - BIT_RESTART_LO] && link_ok;

	// slot order matches flag pairs and restart bits
	assign values[PARAM_EQ]  = dsp_params.eq;
	assign values[PARAM_DG]  = dsp_params.dg;
	assign values[PARAM_BLW] = dsp_params.blw;
	assign values[PARAM_FO]  = dsp_params.fo;
	assign values[PARAM_FC]  = dsp_params.fc;

	// one comparator per parameter; flag 2i is low, 2i+1 is high
	for (genvar i = 0; i < NUM_PARAMS; i++) begin : g_chk
		threshold_check #(
			.W(VAL_W)
		) u_chk (
			.value    (values[i]),
			.thr_lo   (thr_ff[i].lo),
			.thr_hi   (thr_ff[i].hi),
			.active   (mon_active),
			.over_hi  (viol[2*i+1]),
			.under_lo (viol[2*i])
		);
		// restart fires on a fresh violation, not every cycle it lasts
		assign new_viol[i] = |(viol[2*i+1 -: 2] & ~prev_viol_ff[2*i+1 -: 2]);
		assign restart_hit[i] = new_viol[i] && cfg_ff[i];
	end

	assign any_viol = |viol;

	// ahb address phase decode
	assign take    = hsel && htrans[1] && hready;
	assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
	assign a_idx   = haddr[9:2];
	assign thr_sel = 3'(a_idx - IDX_THR_BASE);
	assign rd_ctrl = take && !hwrite && addr_ok && (a_idx == IDX_CTRL);
	assign rd_irq_status = take && !hwrite && addr_ok &&
		(a_idx == IDX_IRQ_STATUS);

	// read data chosen in the address phase, pre-clear value returned
	always_comb begin
		nxt_rdata = 32'h00000000;
		if (!addr_ok) begin
			nxt_rdata = 32'h00000000;
		end else if (a_idx == IDX_CTRL) begin
			nxt_rdata = {16'h0000, cfg_ff, flags_ff};
		end else if (a_idx == IDX_PCS_CTRL) begin
			nxt_rdata = 32'(sd_opt_ff) << BIT_SIGNAL_DETECT_OPTION;
		end else if (a_idx == IDX_IRQ_STATUS) begin
			nxt_rdata = 32'(irq_status_ff) << BIT_IRQ_LQ;
		end else if (a_idx == IDX_IRQ_MASK) begin
			nxt_rdata = 32'(irq_mask_ff) << BIT_IRQ_LQ;
		end else if (a_idx >= IDX_THR_BASE &&
			a_idx < IDX_THR_BASE + 8'(NUM_PARAMS)) begin
			nxt_rdata = {16'h0000, thr_ff[thr_sel]};
		end
	end

	// zero-wait slave, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (take && !hwrite) begin
				hrdata <= nxt_rdata;
			end
		end
	end

	// keep the address phase for the write data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_ff <= '0;
		end else if (hready) begin
			req_ff.wr  <= take && hwrite && addr_ok;
			req_ff.rd  <= take && !hwrite;
			req_ff.idx <= a_idx;
		end
	end

	// software written configuration
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_ff      <= RST_CFG;
			sd_opt_ff   <= RST_SD_OPT;
			irq_mask_ff <= RST_MASK;
		end else if (req_ff.wr) begin
			if (req_ff.idx == IDX_CTRL) begin
				cfg_ff <= hwdata[BIT_MON_ON:BIT_RESTART_LO];
			end else if (req_ff.idx == IDX_PCS_CTRL) begin
				sd_opt_ff <= hwdata[BIT_SIGNAL_DETECT_OPTION];
			end else if (req_ff.idx == IDX_IRQ_MASK) begin
				irq_mask_ff <= hwdata[BIT_IRQ_LQ];
			end
		end
	end

	// threshold registers; write data bits 31:16 are ignored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NUM_PARAMS; i++) begin
				thr_ff[i].lo <= RST_THR_LO;
				thr_ff[i].hi <= RST_THR_HI;
			end
		end else if (req_ff.wr) begin
			for (int i = 0; i < NUM_PARAMS; i++) begin
				if (req_ff.idx == IDX_THR_BASE + 8'(i)) begin
					thr_ff[i] <= hwdata[15:0];
				end
			end
		end
	end

	// sticky flags, set wins over the read clear
	always_comb begin
		nxt_flags = flags_ff;
		if (rd_ctrl) begin
			nxt_flags = RST_FLAGS;
		end
		nxt_flags = nxt_flags | viol;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_ff <= RST_FLAGS;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	// one interrupt event per arming; a control read re-arms
	always_comb begin
		nxt_armed = armed_ff;
		if (armed_ff && any_viol) begin
			nxt_armed = 1'b0;
		end else if (rd_ctrl) begin
			nxt_armed = 1'b1;
		end
		nxt_irq_status = irq_status_ff;
		if (rd_irq_status) begin
			nxt_irq_status = 1'b0;
		end
		if (armed_ff && any_viol) begin
			nxt_irq_status = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed_ff      <= 1'b1;
			irq_status_ff <= 1'b0;
			irq           <= 1'b0;
		end else begin
			armed_ff      <= nxt_armed;
			irq_status_ff <= nxt_irq_status;
			irq           <= irq_status_ff && irq_mask_ff;
		end
	end

	// automatic DSP restart; link drop only without signal detect option
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_viol_ff <= RST_FLAGS;
			dsp_restart  <= 1'b0;
			link_drop    <= 1'b0;
		end else begin
			prev_viol_ff <= viol;
			dsp_restart  <= |restart_hit;
			link_drop    <= |restart_hit && !sd_opt_ff;
		end
	end

	// checks
	chk_flag_sticky: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(flags_ff != 10'h000 && !rd_ctrl) |=>
			((flags_ff & $past(flags_ff)) == $past(flags_ff)))
		else $error("warning flag lost without a read");

	chk_read_clears: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(rd_ctrl && !any_viol) |=> (flags_ff == 10'h000) && armed_ff)
		else $error("control read did not clear flags or re-arm");

	// a violation landing on the read edge must survive the clear
	chk_read_set_wins: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(rd_ctrl && any_viol) |=>
			((flags_ff & $past(viol)) == $past(viol)))
		else $error("violation in the read cycle was lost");

	chk_idle_no_set: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!mon_active |=> ((flags_ff & ~$past(flags_ff)) == 10'h000))
		else $error("flag set while monitor inactive");

	chk_off_threshold: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(thr_ff[PARAM_FC].hi == 8'hFF && thr_ff[PARAM_FC].lo == 8'h00)
			|-> (viol[2*PARAM_FC+1 -: 2] == 2'b00))
		else $error("disabled threshold still tripped");

	chk_irq_raise: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(armed_ff && any_viol && irq_mask_ff && !req_ff.wr)
			|=> ##1 irq)
		else $error("interrupt not raised two cycles after violation");

	chk_fc_high_flag: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(mon_active && dsp_params.fc > thr_ff[PARAM_FC].hi)
			|=> flags_ff[2*PARAM_FC+1])
		else $error("frequency control high flag not set");

	chk_eq_low_flag: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(mon_active && dsp_params.eq < thr_ff[PARAM_EQ].lo)
			|=> flags_ff[2*PARAM_EQ])
		else $error("equalizer low flag not set");

	chk_fc_low_flag: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(mon_active && dsp_params.fc < thr_ff[PARAM_FC].lo)
			|=> flags_ff[2*PARAM_FC])
		else $error("frequency control low flag not set");

	chk_fo_high_flag: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(mon_active && dsp_params.fo > thr_ff[PARAM_FO].hi)
			|=> flags_ff[2*PARAM_FO+1])
		else $error("frequency offset high flag not set");

	chk_blw_low_flag: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(mon_active && dsp_params.blw < thr_ff[PARAM_BLW].lo)
			|=> flags_ff[2*PARAM_BLW])
		else $error("baseline wander low flag not set");

	chk_dg_high_flag: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(mon_active && dsp_params.dg > thr_ff[PARAM_DG].hi)
			|=> flags_ff[2*PARAM_DG+1])
		else $error("digital gain high flag not set");

	chk_fc_restart: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(new_viol[PARAM_FC] && cfg_ff[PARAM_FC]) |=> dsp_restart)
		else $error("frequency control restart missing");

	chk_fo_restart: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(new_viol[PARAM_FO] && cfg_ff[PARAM_FO]) |=> dsp_restart)
		else $error("frequency offset restart missing");

	chk_blw_restart: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(new_viol[PARAM_BLW] && cfg_ff[PARAM_BLW]) |=> dsp_restart)
		else $error("baseline wander restart missing");

	chk_dg_restart: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(new_viol[PARAM_DG] && cfg_ff[PARAM_DG]) |=> dsp_restart)
		else $error("digital gain restart missing");

	chk_eq_restart: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(new_viol[PARAM_EQ] && cfg_ff[PARAM_EQ]) |=> dsp_restart)
		else $error("equalizer restart missing");

	chk_link_drop: assert property (
		@(posedge hclk) disable iff (!hresetn)
		dsp_restart |-> (link_drop == !$past(sd_opt_ff)))
		else $error("link drop does not follow signal detect option");

	chk_drop_needs_restart: assert property (
		@(posedge hclk) disable iff (!hresetn)
		link_drop |-> dsp_restart)
		else $error("link drop without restart");
endmodule : link_quality_monitor_ctrl
`default_nettype wire

// [test/link_quality_monitor_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module link_quality_monitor_ctrl_bench import lqm_pkg::*;;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        link_100_valid;
	dsp_params_t dsp_params;
	logic        irq;
	logic        dsp_restart;
	logic        link_drop;
	logic [31:0] q;
	int          bad_count;
	int          cmp_count;

	link_quality_monitor_ctrl DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .link_100_valid(link_100_valid),
		.dsp_params(dsp_params), .irq(irq), .dsp_restart(dsp_restart),
		.link_drop(link_drop)
	);

	// free-running core clock
	always #5 hclk = ~hclk;

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	// one single AHB transfer; a wait loop that never sees hreadyout ends only by the watchdog
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : xfer

	// two-cycle excursion of parameter slot i, pulses judged 1 ns after the edge
	task automatic hit(input int i, input logic [7:0] v, input logic rs, input logic ld);
		logic [39:0] p;
		p = {5{8'h60}};
		p[8*i +: 8] = v;
		@(posedge hclk);
		dsp_params <= p;
		@(posedge hclk);
		#1;
		chk("dsp_restart", {31'h0, rs}, {31'h0, dsp_restart});
		chk("link_drop", {31'h0, ld}, {31'h0, link_drop});
		@(posedge hclk);
		dsp_params <= {5{8'h60}};
	endtask : hit

	// reset values, unmapped read, writes to flag bits ignored
	task automatic t_reset();
		xfer(1'b0, 32'h74, 32'h0);
		chk("ctrl reset", 32'h0, q);
		xfer(1'b0, 32'h80, 32'h0);
		chk("thr reset", 32'h0000FF00, q);
		xfer(1'b0, 32'h100, 32'h0);
		chk("unmapped", 32'h0, q);
		chk("hresp", 32'h0, {31'h0, hresp});
		xfer(1'b1, 32'h74, 32'h3FF);
		xfer(1'b0, 32'h74, 32'h0);
		chk("flag write", 32'h0, q);
	endtask : t_reset

	// limits at extremes never trip, even at the code extremes
	task automatic t_extremes();
		xfer(1'b1, 32'h74, 32'h8000);
		hit(0, 8'hFF, 1'b0, 1'b0);
		hit(0, 8'h00, 1'b0, 1'b0);
		xfer(1'b0, 32'h74, 32'h0);
		chk("extreme flags", 32'h8000, q);
	endtask : t_extremes

	// every parameter, high then low, with its own restart bit
	task automatic t_params();
		logic [31:0] c;
		for (int i = 0; i < 5; i++) begin
			c = 32'h8000 | (32'h400 << i);
			xfer(1'b1, 32'h80 + 4 * i, 32'h8040);
			xfer(1'b1, 32'h74, c);
			hit(i, 8'h81, 1'b1, 1'b1);
			xfer(1'b0, 32'h74, 32'h0);
			chk("flag hi", c | (32'h2 << 2 * i), q);
			hit(i, 8'h3F, 1'b1, 1'b1);
			xfer(1'b0, 32'h74, 32'h0);
			chk("flag lo", c | (32'h1 << 2 * i), q);
			xfer(1'b0, 32'h74, 32'h0);
			chk("cleared", c, q);
		end
	endtask : t_params

	// interrupt raise, clear, arming, signal detect option set
	task automatic t_irq();
		xfer(1'b1, 32'h4C, 32'h1);
		xfer(1'b1, 32'h40, 32'h100);
		xfer(1'b0, 32'h48, 32'h0);
		xfer(1'b0, 32'h74, 32'h0);
		xfer(1'b1, 32'h74, 32'h8400);
		hit(0, 8'h90, 1'b1, 1'b0);
		// irq updates on the edge hit returns at; look once it settles
		#1;
		chk("irq", 32'h1, {31'h0, irq});
		xfer(1'b0, 32'h48, 32'h0);
		chk("irq status", 32'h1, q);
		repeat (2) @(posedge hclk);
		chk("irq low", 32'h0, {31'h0, irq});
		hit(0, 8'h20, 1'b1, 1'b0);
		xfer(1'b0, 32'h48, 32'h0);
		chk("unarmed", 32'h0, q);
		xfer(1'b0, 32'h74, 32'h0);
		hit(0, 8'h90, 1'b1, 1'b0);
		xfer(1'b0, 32'h48, 32'h0);
		chk("rearmed", 32'h1, q);
		// a status read leaves the flags alone; clear them here
		xfer(1'b0, 32'h74, 32'h0);
		chk("flags kept", 32'h8402, q);
		xfer(1'b1, 32'h74, 32'h0400);
		hit(0, 8'h90, 1'b0, 1'b0);
		xfer(1'b0, 32'h74, 32'h0);
		chk("monitor off", 32'h0400, q);
	endtask : t_irq

	// monitor on but no valid link
	task automatic t_nolink();
		xfer(1'b0, 32'h74, 32'h0);
		xfer(1'b1, 32'h74, 32'h8400);
		@(posedge hclk);
		link_100_valid <= 1'b0;
		repeat (3) @(posedge hclk);
		hit(0, 8'h90, 1'b0, 1'b0);
		xfer(1'b0, 32'h74, 32'h0);
		chk("no link", 32'h8400, q);
	endtask : t_nolink

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		link_100_valid = 1'b1;
		dsp_params = {5{8'h60}};
		bad_count = 0;
		cmp_count = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_extremes();
		t_params();
		t_irq();
		t_nolink();
		close_out();
	end

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge hclk);
		bad_count++;
		close_out();
	end
endmodule : link_quality_monitor_ctrl_bench
`default_nettype wire
